// *** logic/pmt8_pkg.sv ***
// constants shared by the period match timer files
package pmt8_pkg;
	localparam int          ADDR_W         = 3;
	localparam int          DATA_W         = 8;
	// register offsets
	localparam logic [2:0]  OFF_COUNT      = 3'h0;
	localparam logic [2:0]  OFF_CONTROL    = 3'h1;
	localparam logic [2:0]  OFF_PERIOD     = 3'h2;
	localparam logic [2:0]  OFF_FLAGS      = 3'h3;
	localparam logic [2:0]  OFF_ENABLES    = 3'h4;
	localparam logic [2:0]  OFF_PRIORITY   = 3'h5;
	// reset values
	localparam logic [7:0]  RST_COUNT      = 8'h00;
	localparam logic [7:0]  RST_CONTROL    = 8'h00;
	localparam logic [7:0]  RST_PERIOD     = 8'hff;
	localparam logic [7:0]  RST_ZERO       = 8'h00;
	// control field layout
	localparam int          CTL_PRE_LSB    = 0;
	localparam int          CTL_PRE_MSB    = 1;
	localparam int          CTL_RUN_BIT    = 2;
	localparam int          CTL_POST_LSB   = 3;
	localparam int          CTL_POST_MSB   = 6;
	localparam logic [7:0]  CTL_WR_MASK    = 8'h7f;
	// flag, enable and priority bit position
	localparam int          IRQ_BIT        = 3;
	// prescale select codes and terminal counts
	localparam logic [1:0]  PRE_DIV1       = 2'h0;
	localparam logic [1:0]  PRE_DIV4       = 2'h1;
	localparam logic [3:0]  PRE_LIM1       = 4'h0;
	localparam logic [3:0]  PRE_LIM4       = 4'h3;
	localparam logic [3:0]  PRE_LIM16      = 4'hf;
	// oscillator to instruction clock ratio
	localparam int          OSC_DIV        = 4;
	localparam logic [1:0]  OSC_LIM        = 2'(OSC_DIV - 1);
endpackage

// *** logic/pmt8_scaler.sv ***
// free counting divider with synchronous clear and a terminal pulse
`timescale 1ns/100ps
module pmt8_scaler #(
	parameter int W = 4
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         clr_i,
	input  wire logic         en_i,
	input  wire logic [W-1:0] limit_i,
	output logic      [W-1:0] count_o,
	output logic              pulse_o
);
	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;

	// ====================================================
	// terminal detect and next count
	assign pulse_o    = en_i && (count_reg == limit_i);
	assign count_next = clr_i ? '0 :
	                    pulse_o ? '0 :
	                    en_i ? W'(count_reg + 1'b1) : count_reg;
	assign count_o    = count_reg;

	// clear wins over counting so a write restarts the ratio cleanly
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end
endmodule // pmt8_scaler

// *** logic/pmt8_timer.sv ***
// period match timer: 8-bit counter, prescaler, postscaler, registers
// Operation
// [R1] count up from zero each tick, wrap to zero after equalling the period
// [R2] period register resets to all ones
// [R3] count register is read/write and clears on reset
// [R4] prescale select: 00 divide 1, 01 divide 4, 1x divide 16
// [R5] matches pass a 4-bit postscaler before setting the flag
// [R6] postscale ratio is select value plus one, 1:1 to 1:16
// [R7] writes to count or control, and reset, clear both scalers
// [R8] a control write leaves the count unchanged
// [R9] control bit 2 runs the timer; zero stops it
// [R10] control bit 7 reads as zero
// [R11] raw match goes out only as the pwm time base
// [R12] period register is read/write at any time
// [R13] postscaled match latches flag bit 3; enable and priority at bit 3
// [R14] software clears the flag; it stays set until then
// [R15] while stopped, count holds and scalers do not advance
`timescale 1ns/100ps
module pmt8_timer (
	input  wire logic                         core_clk_i,
	input  wire logic                         rst_n_i,
	input  wire logic [pmt8_pkg::ADDR_W-1:0]  addr_i,
	input  wire logic [pmt8_pkg::DATA_W-1:0]  wr_data_i,
	input  wire logic                         wr_en_i,
	input  wire logic                         rd_en_i,
	output logic      [pmt8_pkg::DATA_W-1:0]  rd_data_o,
	output logic                              irq_o,
	output logic                              irq_priority_o,
	output logic                              pwm_timebase_o,
	output logic      [pmt8_pkg::DATA_W-1:0]  tick_count_o
);
	import pmt8_pkg::*;

	// ====================================================
	// reset synchroniser
	logic       rst_meta_reg;
	logic       rst_n;

	// assert at once, release two edges later so no flop sees a runt release
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	// ====================================================
	// registers and decode
	logic [7:0] tick_count_reg;
	logic [7:0] tick_count_next;
	logic [7:0] timer_control_reg;
	logic [7:0] period_value_reg;
	logic       match_irq_flag_reg;
	logic       match_irq_flag_next;
	logic       match_irq_enable_reg;
	logic       match_irq_priority_reg;
	logic [7:0] rd_data_reg;
	logic [7:0] rd_data_next;
	logic       match_reg;

	logic       wr_count;
	logic       wr_control;
	logic       wr_period;
	logic       wr_flags;
	logic       wr_enables;
	logic       wr_priority;
	logic       rd_flags;

	// strobe decode
	assign wr_count    = wr_en_i && (addr_i == OFF_COUNT);
	assign wr_control  = wr_en_i && (addr_i == OFF_CONTROL);
	assign wr_period   = wr_en_i && (addr_i == OFF_PERIOD);
	assign wr_flags    = wr_en_i && (addr_i == OFF_FLAGS);
	assign wr_enables  = wr_en_i && (addr_i == OFF_ENABLES);
	assign wr_priority = wr_en_i && (addr_i == OFF_PRIORITY);
	assign rd_flags    = rd_en_i && (addr_i == OFF_FLAGS);

	// ====================================================
	// control fields
	logic [1:0] prescale_select;
	logic [3:0] postscale_select;
	logic       run_enable;

	assign prescale_select  = timer_control_reg[CTL_PRE_MSB:CTL_PRE_LSB];
	assign postscale_select = timer_control_reg[CTL_POST_MSB:CTL_POST_LSB];
	assign run_enable       = timer_control_reg[CTL_RUN_BIT]; // R9

	// ====================================================
	// scaler chain
	logic       instr_tick;
	logic       pre_tick;
	logic       post_tick;
	logic       scaler_clr;
	logic [3:0] pre_limit;
	logic [3:0] pre_count;
	logic [3:0] post_count;
	logic       match_now;
	logic       pre_step;

	// any count or control write restarts both ratios
	assign scaler_clr = wr_count || wr_control; // R7

	// a tick landing on a count or control write is dropped, so a control
	// write never moves the count and a count write is never overtaken
	assign pre_step   = pre_tick && !scaler_clr; // R8

	// terminal count for the prescaler, upper code bit alone picks 1:16
	assign pre_limit  = (prescale_select == PRE_DIV1) ? PRE_LIM1 :
	                    (prescale_select == PRE_DIV4) ? PRE_LIM4 : PRE_LIM16; // R4

	// instruction clock enable: oscillator divided down, never cleared
	pmt8_scaler #(
		.W(2)
	) u_instr_div (
		.clk_i   (core_clk_i),
		.rst_n_i (rst_n),
		.clr_i   (1'b0),
		.en_i    (1'b1),
		.limit_i (OSC_LIM),
		.count_o (),
		.pulse_o (instr_tick)
	);

	// prescaler only sees instruction ticks while running
	pmt8_scaler #(
		.W(4)
	) u_prescale (
		.clk_i   (core_clk_i),
		.rst_n_i (rst_n),
		.clr_i   (scaler_clr),
		.en_i    (instr_tick && run_enable), // R15
		.limit_i (pre_limit),
		.count_o (pre_count),
		.pulse_o (pre_tick)
	);

	// match occurs on the increment that wraps the counter
	assign match_now = pre_step && (tick_count_reg == period_value_reg); // R1

	// postscaler counts matches, pulses on the select value plus one
	pmt8_scaler #(
		.W(4)
	) u_postscale (
		.clk_i   (core_clk_i),
		.rst_n_i (rst_n),
		.clr_i   (scaler_clr),
		.en_i    (match_now && !scaler_clr),
		.limit_i (postscale_select), // R6
		.count_o (post_count),
		.pulse_o (post_tick) // R5
	);

	// ====================================================
	// counter next value; software write wins over a tick
	assign tick_count_next = wr_count ? wr_data_i : // R3
	                         match_now ? RST_COUNT : // R1
	                         pre_step ? 8'(tick_count_reg + 1'b1) :
	                         tick_count_reg; // R8

	// flag: hardware set wins over a read clear or a written zero
	assign match_irq_flag_next = post_tick ? 1'b1 : // R13
	                             rd_flags ? 1'b0 :
	                             wr_flags ? wr_data_i[IRQ_BIT] && match_irq_flag_reg :
	                             match_irq_flag_reg; // R14

	// ====================================================
	// read mux; unmapped offsets answer zero
	always_comb begin
		rd_data_next = RST_ZERO;
		unique case (addr_i)
			OFF_COUNT: begin
				rd_data_next = tick_count_reg;
			end
			OFF_CONTROL: begin
				rd_data_next = timer_control_reg & CTL_WR_MASK; // R10
			end
			OFF_PERIOD: begin
				rd_data_next = period_value_reg; // R12
			end
			OFF_FLAGS: begin
				rd_data_next[IRQ_BIT] = match_irq_flag_reg;
			end
			OFF_ENABLES: begin
				rd_data_next[IRQ_BIT] = match_irq_enable_reg;
			end
			OFF_PRIORITY: begin
				rd_data_next[IRQ_BIT] = match_irq_priority_reg;
			end
			default: begin
				rd_data_next = RST_ZERO;
			end
		endcase
	end

	// ====================================================
	// counter, period and control storage
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tick_count_reg    <= RST_COUNT; // R3
			timer_control_reg <= RST_CONTROL;
			period_value_reg  <= RST_PERIOD; // R2
		end else begin
			tick_count_reg <= tick_count_next;
			if (wr_control) begin
				timer_control_reg <= wr_data_i & CTL_WR_MASK; // R10
			end
			if (wr_period) begin
				period_value_reg <= wr_data_i; // R12
			end
		end
	end

	// interrupt bits and bus answer
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			match_irq_flag_reg     <= 1'b0;
			match_irq_enable_reg   <= 1'b0;
			match_irq_priority_reg <= 1'b0;
			rd_data_reg            <= RST_ZERO;
			match_reg              <= 1'b0;
		end else begin
			match_irq_flag_reg <= match_irq_flag_next;
			if (wr_enables) begin
				match_irq_enable_reg <= wr_data_i[IRQ_BIT];
			end
			if (wr_priority) begin
				match_irq_priority_reg <= wr_data_i[IRQ_BIT];
			end
			if (rd_en_i) begin
				rd_data_reg <= rd_data_next;
			end
			match_reg <= match_now; // R11
		end
	end

	// ====================================================
	// outputs
	assign rd_data_o      = rd_data_reg;
	assign irq_o          = match_irq_flag_reg && match_irq_enable_reg;
	assign irq_priority_o = match_irq_priority_reg; // R13
	// raw match, ahead of the postscaler, only for the pwm modules
	assign pwm_timebase_o = match_reg; // R11
	assign tick_count_o   = tick_count_reg;

	// ====================================================
	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n);

	sequence wrap_cause_s;
		pre_step && !wr_count && (tick_count_reg == period_value_reg);
	endsequence
	sequence at_zero_s;
		tick_count_reg == RST_COUNT;
	endsequence

	wrap_to_zero_a: assert property (wrap_cause_s |=> at_zero_s) // R1
		else $error("counter did not wrap to zero");
	count_step_a: assert property (pre_step && !wr_count
		&& (tick_count_reg != period_value_reg)
		|=> tick_count_reg == 8'($past(tick_count_reg) + 1'b1)) // R1
		else $error("counter did not step by one");
	period_reset_a: assert property ($rose(rst_n) |-> period_value_reg == RST_PERIOD) // R2
		else $error("period not all ones after reset");
	count_write_a: assert property (wr_count |=> tick_count_reg == $past(wr_data_i)) // R3
		else $error("count write lost");
	pre_ratio_a: assert property (pre_tick |-> instr_tick && pre_count == pre_limit) // R4
		else $error("prescale tick at wrong count");
	post_ratio_a: assert property (post_tick |-> match_now
		&& post_count == postscale_select) // R6
		else $error("postscale pulse at wrong count");
	flag_latch_a: assert property (post_tick |=> match_irq_flag_reg) // R5
		else $error("flag not latched after postscale");
	scaler_clear_a: assert property (scaler_clr
		|=> pre_count == 4'h0 && post_count == 4'h0) // R7
		else $error("scalers not cleared by write");
	ctl_keeps_count_a: assert property (wr_control && !wr_count
		|=> $stable(tick_count_reg)) // R8
		else $error("control write changed count");
	stop_hold_a: assert property (!run_enable && !wr_count
		|-> !pre_tick ##1 $stable(tick_count_reg)) // R15
		else $error("stopped timer moved");
	bit7_zero_a: assert property (rd_en_i && addr_i == OFF_CONTROL
		|=> !rd_data_o[7]) // R10
		else $error("control bit 7 read as one");
	timebase_only_a: assert property (pwm_timebase_o |-> $past(match_now)) // R11
		else $error("time base pulse without match");
	period_write_a: assert property (wr_period |=> period_value_reg == $past(wr_data_i)) // R12
		else $error("period write lost");
	flag_sticky_a: assert property (match_irq_flag_reg && !rd_flags && !wr_flags
		|=> match_irq_flag_reg) // R14
		else $error("flag dropped without software");

	// a software clear only loses to a same-cycle set
	sequence flag_clear_s;
		(rd_flags || (wr_flags && !wr_data_i[IRQ_BIT])) && !post_tick;
	endsequence

	flag_clear_a: assert property (flag_clear_s |=> !match_irq_flag_reg) // R14
		else $error("flag survived a software clear");
	write_no_tick_a: assert property (scaler_clr |-> !match_now && !post_tick) // R7
		else $error("tick counted through a scaler clear");
	// period only moves on a write, never by itself
	period_hold_a: assert property (!wr_period |=> $stable(period_value_reg)) // R12
		else $error("period changed without a write");
endmodule // pmt8_timer

// *** verif/pmt8_pwm_model.sv ***
// model of the pwm module that consumes the timer's raw match pulse
`timescale 1ns/100ps
module pmt8_pwm_model (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        timebase_i,
	output logic      [15:0] pulse_cnt_o,
	output logic      [15:0] gap_o
);
	logic [15:0] cyc_reg;
	// ========================================
	// time base tracking
	// counts pulses and the clocks between two of them; the pulse is the
	// only thing the pwm side takes from the timer, so spacing is its view
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pulse_cnt_o <= 16'h0000;
			gap_o       <= 16'h0000;
			cyc_reg     <= 16'h0000;
		end else if (timebase_i) begin
			pulse_cnt_o <= pulse_cnt_o + 16'h0001;
			gap_o       <= cyc_reg + 16'h0001;
			cyc_reg     <= 16'h0000;
		end else begin
			cyc_reg <= cyc_reg + 16'h0001;
		end
	end
endmodule // pmt8_pwm_model

// *** verif/tb_period_match_timer8.sv ***
// self-checking bench for the period match timer
`timescale 1ns/100ps
module tb_period_match_timer8;
	import pmt8_pkg::*;
	logic              core_clk;
	logic              rst_n;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wr_data;
	logic              wr_en;
	logic              rd_en;
	logic [DATA_W-1:0] rd_data;
	logic              irq;
	logic              irq_pri;
	logic              timebase;
	logic [DATA_W-1:0] tick_count;
	logic [15:0]       pulse_cnt;
	logic [15:0]       gap;
	logic [15:0]       base;
	logic [7:0]        d;
	int                errors;
	int                compares;

	pmt8_timer pmt8_timer_inst (.core_clk_i(core_clk), .rst_n_i(rst_n), .addr_i(addr),
		.wr_data_i(wr_data), .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd_data),
		.irq_o(irq), .irq_priority_o(irq_pri), .pwm_timebase_o(timebase),
		.tick_count_o(tick_count));
	pmt8_pwm_model pmt8_pwm_model_inst (.clk_i(core_clk), .rst_n_i(rst_n),
		.timebase_i(timebase), .pulse_cnt_o(pulse_cnt), .gap_o(gap));

	// ========================================
	// clock and reporting
	always #5 core_clk = ~core_clk;

	task automatic wrap_up();
		if (errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// ========================================
	// register bus: one-cycle strobes, data the cycle after a read
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
		@(posedge core_clk);
		wr_en   <= 1'b1;
		addr    <= a;
		wr_data <= v;
		@(posedge core_clk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
		@(posedge core_clk);
		rd_en <= 1'b1;
		addr  <= a;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1 v = rd_data;
	endtask

	// bounded waits: a hang counts as a mismatch and ends the run
	task automatic wait_pulses(input int n);
		base = pulse_cnt;
		for (int i = 0; i < 3000 && pulse_cnt !== base + 16'(n); i++) @(posedge core_clk);
		if (pulse_cnt !== base + 16'(n)) begin
			errors++;
			wrap_up();
		end
	endtask

	task automatic wait_irq();
		for (int i = 0; i < 600 && irq !== 1'b1; i++) begin
			@(posedge core_clk);
			#1;
		end
		if (irq !== 1'b1) begin
			errors++;
			wrap_up();
		end
	endtask

	// divide by 16 from a freshly cleared prescaler: no step before 16 ticks
	task automatic pre16_chk();
		repeat (55) @(posedge core_clk);
		#1 chk(tick_count, 16'h0000);
		repeat (14) @(posedge core_clk);
		#1 chk(tick_count, 16'h0001);
	endtask

	// ========================================
	// main sequence
	initial begin
		core_clk = 1'b0;
		rst_n    = 1'b0;
		addr     = '0;
		wr_data  = '0;
		wr_en    = 1'b0;
		rd_en    = 1'b0;
		errors   = 0;
		compares = 0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		// reset values, access kinds, unmapped offsets
		rd(OFF_COUNT, d); chk(d, 16'h0000);
		rd(OFF_CONTROL, d); chk(d, 16'h0000);
		rd(OFF_PERIOD, d); chk(d, 16'h00ff);
		wr(OFF_CONTROL, 8'hfb); rd(OFF_CONTROL, d); chk(d, 16'h007b);
		wr(OFF_CONTROL, 8'h00);
		wr(OFF_PERIOD, 8'h5a); rd(OFF_PERIOD, d); chk(d, 16'h005a);
		wr(OFF_COUNT, 8'ha5); rd(OFF_COUNT, d); chk(d, 16'h00a5);
		wr(3'h6, 8'h55); rd(3'h6, d); chk(d, 16'h0000);
		rd(3'h7, d); chk(d, 16'h0000);
		wr(OFF_PRIORITY, 8'h08); #1 chk(irq_pri, 16'h0001);
		// every prescale code, period 2: pulses every 3 * 4 * divide clocks
		wr(OFF_PERIOD, 8'h02);
		for (int p = 0; p < 4; p++) begin
			wr(OFF_CONTROL, 8'h04 | 8'(p));
			wait_pulses(2);
			#1 chk(gap, 16'(12 * (p == 0 ? 1 : (p == 1 ? 4 : 16))));
		end
		// scaler clear by a control write, then by a count write
		wr(OFF_CONTROL, 8'h00);
		wr(OFF_PERIOD, 8'hff);
		wr(OFF_COUNT, 8'h00);
		wr(OFF_CONTROL, 8'h06);
		pre16_chk();
		repeat (30) @(posedge core_clk);
		wr(OFF_COUNT, 8'h00);
		pre16_chk();
		// control write keeps the count; stopped timer holds it
		wr(OFF_CONTROL, 8'h00);
		wr(OFF_COUNT, 8'h33);
		wr(OFF_CONTROL, 8'h02);
		repeat (80) @(posedge core_clk);
		rd(OFF_COUNT, d); chk(d, 16'h0033);
		// every postscale code: flag on match number code plus one
		wr(OFF_PERIOD, 8'h01);
		wr(OFF_ENABLES, 8'h08);
		rd(OFF_FLAGS, d);
		for (int k = 0; k < 16; k++) begin
			wr(OFF_COUNT, 8'h00);
			wr(OFF_CONTROL, 8'(k << 3) | 8'h04);
			base = pulse_cnt;
			wait_irq();
			repeat (2) @(posedge core_clk);
			#1 chk(pulse_cnt - base, 16'(k + 1));
			wr(OFF_CONTROL, 8'h00);
			if (k == 0) begin
				#1 chk(irq, 16'h0001);
				wr(OFF_ENABLES, 8'h00); #1 chk(irq, 16'h0000);
				wr(OFF_ENABLES, 8'h08); #1 chk(irq, 16'h0001);
				wr(OFF_FLAGS, 8'h00); #1 chk(irq, 16'h0000);
			end else begin
				rd(OFF_FLAGS, d); chk(d, 16'h0008);
				#1 chk(irq, 16'h0000);
			end
		end
		// mid-run reset: counter, period and control go back to reset values
		wr(OFF_PERIOD, 8'h40);
		wr(OFF_CONTROL, 8'h04);
		repeat (40) @(posedge core_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 chk(tick_count, 16'h0000);
		@(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd(OFF_PERIOD, d); chk(d, 16'h00ff);
		rd(OFF_CONTROL, d); chk(d, 16'h0000);
		repeat (100) @(posedge core_clk);
		#1 chk(tick_count, 16'h0000);
		wrap_up();
	end
endmodule // tb_period_match_timer8
